// *** hdl/stc_serializer_tx.sv ***
/*
  Word FIFO and the serializer transmit control top.
  Assumes pins arrive asynchronously to hclk and that hclk runs well
  above the word clock; the LVDS driver and bit-rate PLL sit outside.
*/
`timescale 1ns/10ps

module stc_fifo #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     flush,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [W-1:0]             in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [W-1:0]                  out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign level     = ($clog2(DEPTH+1))'(wr_ptr - rd_ptr);
  assign in_ready  = (level != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge hclk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule // stc_fifo

module stc_serializer_tx #(
  parameter int unsigned SYNC_BURST_LEN = stc_pkg::SYNC_BURST,
  parameter int unsigned LOCK_CYCLES    = stc_pkg::LOCK_WAIT
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // parallel side pins
  input  wire logic                       word_clock,
  input  wire logic                       capture_edge_select,
  input  wire logic [stc_pkg::WORD_W-1:0] parallel_word_in,
  input  wire logic                       pattern_request_a,
  input  wire logic                       pattern_request_b,
  input  wire logic                       serial_out_enable,
  input  wire logic                       sleep_control,
  // serial side
  output logic                            serial_p_out,
  output logic                            serial_p_oe,
  output logic                            serial_n_out,
  output logic                            serial_n_oe,
  output logic [stc_pkg::SYM_W-1:0]       serial_symbol,
  output logic                            symbol_strobe
);
  localparam int unsigned LW = $clog2(stc_pkg::FIFO_DEPTH+1);

  stc_pkg::stc_pins_s  pins_in;
  stc_pkg::stc_pins_s  pins_s1;
  stc_pkg::stc_pins_s  pins_s2;
  logic                wc_d;
  logic                wc_rise;
  logic                wc_fall;
  logic                capture_edge;
  logic                req;
  stc_pkg::stc_state_e state;
  stc_pkg::stc_state_e next_state;
  logic [10:0]         lock_cnt;
  logic [2:0]          hold_cnt;
  logic [10:0]         burst_left;
  logic                hold_hit;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [stc_pkg::WORD_W-1:0] fifo_out_data;
  logic [LW-1:0]       fifo_level;
  logic                fifo_flush;
  logic                push_req;
  logic                pop_req;
  logic [stc_pkg::SYM_W-1:0] shreg;
  logic                ctrl_gate;
  logic                underrun;
  logic                overflow;
  logic                a_wr;
  logic [7:0]          a_addr;
  logic                take;
  logic [31:0]         rd_mux;

  assign pins_in = '{word_clock:          word_clock,
                     capture_edge_select: capture_edge_select,
                     parallel_word_in:    parallel_word_in,
                     pattern_request_a:   pattern_request_a,
                     pattern_request_b:   pattern_request_b,
                     serial_out_enable:   serial_out_enable,
                     sleep_control:       sleep_control};

  // two-flop synchroniser for every pin; only stage two is read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      wc_d    <= 1'b0;
    end
    else
    begin
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      wc_d    <= pins_s2.word_clock;
    end
  end

  // word clock paces capture and symbol boundaries
  assign wc_rise      = pins_s2.word_clock && !wc_d;
  assign wc_fall      = !pins_s2.word_clock && wc_d;
  assign capture_edge = pins_s2.capture_edge_select ? wc_rise : wc_fall;
  assign req          = pins_s2.pattern_request_a || pins_s2.pattern_request_b;
  // sixth or any later consecutive high boundary, counting this one
  assign hold_hit     = wc_rise && req && (hold_cnt >= 3'(stc_pkg::SYNC_HOLD - 1));

  always_comb
  begin
    next_state = state;
    case (state)
      stc_pkg::STC_SLEEP:
        if (pins_s2.sleep_control)
          next_state = stc_pkg::STC_LOCKING;
      stc_pkg::STC_LOCKING:
        if (wc_rise && lock_cnt == 11'(LOCK_CYCLES - 1))
          next_state = stc_pkg::STC_DATA;
      stc_pkg::STC_DATA:
        if (hold_hit)
          next_state = stc_pkg::STC_SYNC;
      stc_pkg::STC_SYNC:
        if (wc_rise && burst_left <= 11'd1 && !req && !hold_hit)
          next_state = stc_pkg::STC_DATA;
      default:
        next_state = stc_pkg::STC_SLEEP;
    endcase
    if (!pins_s2.sleep_control)
      next_state = stc_pkg::STC_SLEEP;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= stc_pkg::STC_SLEEP;
    else
      state <= next_state;
  end

  // pll stand-in: relock takes a fixed count of word clock cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_cnt <= '0;
    else if (state != stc_pkg::STC_LOCKING)
      lock_cnt <= '0;
    else if (wc_rise)
      lock_cnt <= lock_cnt + 11'd1;
  end

  // consecutive high boundaries, saturating so one hold fires once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_cnt <= '0;
    else if (wc_rise)
    begin
      if (!req)
        hold_cnt <= '0;
      else if (hold_cnt < 3'(stc_pkg::SYNC_HOLD))
        hold_cnt <= hold_cnt + 3'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      burst_left <= '0;
    else if (next_state == stc_pkg::STC_SLEEP)
      burst_left <= '0;
    // a hold already saturated when data mode starts still gets a full burst
    else if (hold_hit && (state == stc_pkg::STC_DATA
             || (state == stc_pkg::STC_SYNC && hold_cnt == 3'(stc_pkg::SYNC_HOLD - 1))))
      burst_left <= 11'(SYNC_BURST_LEN);
    else if (wc_rise && state == stc_pkg::STC_SYNC && burst_left != '0)
      burst_left <= burst_left - 11'd1;
  end

  // captures blocked outside data mode so sync ignores the inputs
  assign push_req   = capture_edge && state == stc_pkg::STC_DATA
                      && next_state == stc_pkg::STC_DATA;
  assign pop_req    = wc_rise && next_state == stc_pkg::STC_DATA;
  assign fifo_flush = state == stc_pkg::STC_SLEEP || state == stc_pkg::STC_SYNC;

  stc_fifo #(
    .W     (stc_pkg::WORD_W),
    .DEPTH (stc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (fifo_flush),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (pins_s2.parallel_word_in),
    .out_valid (fifo_out_valid),
    .out_ready (pop_req),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // one symbol per word period; lane shifts one bit per hclk from the msb
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_symbol <= '0;
      shreg         <= '0;
      symbol_strobe <= 1'b0;
    end
    else
    begin
      symbol_strobe <= 1'b0;
      if (wc_rise && next_state == stc_pkg::STC_SYNC)
      begin
        serial_symbol <= stc_pkg::SYNC_SYMBOL;
        shreg         <= stc_pkg::SYNC_SYMBOL;
        symbol_strobe <= 1'b1;
      end
      else if (pop_req)
      begin
        // empty fifo sends a framed zero word so the embedded clock survives
        serial_symbol <= {stc_pkg::START_BIT,
                          fifo_out_valid ? fifo_out_data : 10'h000,
                          stc_pkg::STOP_BIT};
        shreg         <= {stc_pkg::START_BIT,
                          fifo_out_valid ? fifo_out_data : 10'h000,
                          stc_pkg::STOP_BIT};
        symbol_strobe <= 1'b1;
      end
      else
        shreg <= {shreg[stc_pkg::SYM_W-2:0], stc_pkg::STOP_BIT};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_p_out <= 1'b0;
      serial_n_out <= 1'b1;
      serial_p_oe  <= 1'b0;
      serial_n_oe  <= 1'b0;
    end
    else
    begin
      serial_p_out <= shreg[stc_pkg::SYM_W-1];
      serial_n_out <= !shreg[stc_pkg::SYM_W-1];
      // float while disabled, asleep or not yet locked
      serial_p_oe  <= pins_s2.serial_out_enable && ctrl_gate
                      && (state == stc_pkg::STC_DATA || state == stc_pkg::STC_SYNC);
      serial_n_oe  <= pins_s2.serial_out_enable && ctrl_gate
                      && (state == stc_pkg::STC_DATA || state == stc_pkg::STC_SYNC);
    end
  end

  // ahb-lite slave, zero wait states
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    rd_mux = '0;
    case (haddr[7:0])
      stc_pkg::CTRL_OFS:
        rd_mux[stc_pkg::CTRL_GATE_BIT] = ctrl_gate;
      stc_pkg::STATUS_OFS:
      begin
        rd_mux[stc_pkg::ST_LOCKED_BIT]   = state == stc_pkg::STC_DATA
                                           || state == stc_pkg::STC_SYNC;
        rd_mux[stc_pkg::ST_SYNC_BIT]     = state == stc_pkg::STC_SYNC;
        rd_mux[stc_pkg::ST_UNDERRUN_BIT] = underrun;
        rd_mux[stc_pkg::ST_OVERFLOW_BIT] = overflow;
        rd_mux[stc_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
      end
      stc_pkg::SYMBOL_OFS:
        rd_mux[stc_pkg::SYM_W-1:0] = serial_symbol;
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr   <= 1'b0;
      a_addr <= '0;
      hrdata <= '0;
    end
    else
    begin
      a_wr <= take && hwrite;
      if (take)
        a_addr <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_gate <= stc_pkg::CTRL_RST[0];
    else if (a_wr && a_addr == stc_pkg::CTRL_OFS)
      ctrl_gate <= hwdata[stc_pkg::CTRL_GATE_BIT];
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      underrun <= 1'b0;
      overflow <= 1'b0;
    end
    else
    begin
      underrun <= (pop_req && !fifo_out_valid) || (underrun && !(a_wr
                  && a_addr == stc_pkg::STATUS_OFS && hwdata[stc_pkg::ST_UNDERRUN_BIT]));
      overflow <= (push_req && !fifo_in_ready) || (overflow && !(a_wr
                  && a_addr == stc_pkg::STATUS_OFS && hwdata[stc_pkg::ST_OVERFLOW_BIT]));
    end
  end
endmodule // stc_serializer_tx

// *** common/stc_pkg.sv ***
/*
  Constants, pin bundle and state type of the serializer transmit control.
  Assumes one clock (hclk, 20 MHz) and an AHB-Lite master for the registers.
*/
package stc_pkg;
  localparam int unsigned WORD_W      = 10;
  localparam int unsigned SYM_W       = 12;
  localparam int unsigned FIFO_DEPTH  = 4;
  localparam int unsigned SYNC_HOLD   = 6;
  localparam int unsigned SYNC_BURST  = 1026;
  localparam int unsigned LOCK_WAIT   = 1026;
  localparam logic [11:0] SYNC_SYMBOL = 12'hFC0;
  localparam logic        START_BIT   = 1'b1;
  localparam logic        STOP_BIT    = 1'b0;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  SYMBOL_OFS  = 8'h08;
  // control fields
  localparam int unsigned CTRL_GATE_BIT = 0;
  localparam logic [0:0]  CTRL_RST      = 1'h1;
  // status fields
  localparam int unsigned ST_LOCKED_BIT   = 0;
  localparam int unsigned ST_SYNC_BIT     = 1;
  localparam int unsigned ST_UNDERRUN_BIT = 2;
  localparam int unsigned ST_OVERFLOW_BIT = 3;
  localparam int unsigned ST_LEVEL_LSB    = 8;

  typedef struct packed {
    logic              word_clock;
    logic              capture_edge_select;
    logic [WORD_W-1:0] parallel_word_in;
    logic              pattern_request_a;
    logic              pattern_request_b;
    logic              serial_out_enable;
    logic              sleep_control;
  } stc_pins_s;

  typedef enum logic [1:0] {STC_SLEEP, STC_LOCKING, STC_DATA, STC_SYNC} stc_state_e;
endpackage

// *** testbench/stc_serializer_tx_monitor.sv ***
/*
  Pin checker of the serializer transmit control.
  Assumes hclk 50 ns and a word clock of 8 hclk per word.
*/
`timescale 1ns/10ps
module stc_serializer_tx_monitor (
  // clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // pins
  input wire logic                       serial_out_enable,
  input wire logic                       sleep_control,
  input wire logic                       pattern_request_a,
  input wire logic                       pattern_request_b,
  // serial side
  input wire logic                       serial_p_out,
  input wire logic                       serial_p_oe,
  input wire logic                       serial_n_out,
  input wire logic                       serial_n_oe,
  input wire logic [stc_pkg::SYM_W-1:0]  serial_symbol,
  input wire logic                       symbol_strobe
);
  logic [6:0] req_cnt;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // saturating run length of the combined request
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      req_cnt <= 7'h00;
    else if (!(pattern_request_a || pattern_request_b))
      req_cnt <= 7'h00;
    else if (req_cnt != 7'h7F)
      req_cnt <= req_cnt + 7'h01;
  a_oe_pair: assert property (
    serial_p_oe == serial_n_oe) else $error("enables differ");
  a_lane_compl: assert property (
    serial_n_out == !serial_p_out) else $error("lane not complementary");
  a_oe_off_den: assert property (
    !serial_out_enable [*5] |-> !serial_p_oe) else $error("driven while disabled");
  // sync lag of the pin is 3 or 4 edges
  a_oe_cause: assert property (
    serial_p_oe |-> $past(serial_out_enable, 3) || $past(serial_out_enable, 4))
    else $error("driven without enable");
  a_sleep_float: assert property (
    !sleep_control [*6] |-> !serial_p_oe && !serial_n_oe) else $error("driven asleep");
  a_sleep_quiet: assert property (
    !sleep_control [*6] |-> !symbol_strobe) else $error("symbol asleep");
  a_strobe_gap: assert property (
    symbol_strobe |=> !symbol_strobe [*6]) else $error("symbols too close");
  a_symbol_frame: assert property (
    symbol_strobe |-> serial_symbol[11] == stc_pkg::START_BIT
      && serial_symbol[0] == stc_pkg::STOP_BIT) else $error("bad framing");
  a_sync_hold: assert property (
    symbol_strobe && req_cnt >= 7'h48 |-> serial_symbol == stc_pkg::SYNC_SYMBOL)
    else $error("data sent under request");
endmodule // stc_serializer_tx_monitor

bind stc_serializer_tx stc_serializer_tx_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .serial_out_enable(serial_out_enable),
  .sleep_control(sleep_control), .pattern_request_a(pattern_request_a),
  .pattern_request_b(pattern_request_b), .serial_p_out(serial_p_out),
  .serial_p_oe(serial_p_oe), .serial_n_out(serial_n_out), .serial_n_oe(serial_n_oe),
  .serial_symbol(serial_symbol), .symbol_strobe(symbol_strobe));

// *** testbench/stc_source_model.sv ***
/*
  Parallel word source: free-running word clock, one word per half period.
  Assumes a 400 ns word period, oversampled by hclk.
*/
`timescale 1ns/10ps
module stc_source_model (
  // words held around each edge
  input wire logic [stc_pkg::WORD_W-1:0] word_rise,
  input wire logic [stc_pkg::WORD_W-1:0] word_fall,
  // pins
  output logic                           word_clock,
  output logic [stc_pkg::WORD_W-1:0]     parallel_word_in
);
  // rate scaled down from the real range so hclk can sample it
  // data moves between hclk edges, well ahead of the word clock edge
  initial
  begin
    word_clock = 1'b0;
    #200;
    forever
    begin
      word_clock = 1'b1;
      #150 parallel_word_in = word_fall;
      #50 word_clock = 1'b0;
      #150 parallel_word_in = word_rise;
      #50;
    end
  end
endmodule // stc_source_model

// *** testbench/tb_stc_serializer_tx.sv ***
/*
  Self-checking bench of the serializer transmit control.
  Assumes hclk 50 ns and the source model as the word side.
*/
`timescale 1ns/10ps
module tb_stc_serializer_tx;
  localparam int unsigned LOCKN = 8;
  localparam int unsigned BURSTN = 10;
  localparam logic [9:0] WA = 10'h2B5;
  localparam logic [9:0] WB = 10'h14A;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        word_clock, capture_edge_select, pattern_request_a, pattern_request_b;
  logic        serial_out_enable, sleep_control, serial_p_out, serial_p_oe;
  logic        serial_n_out, serial_n_oe, symbol_strobe;
  logic [9:0]  parallel_word_in;
  logic [11:0] serial_symbol;
  int          fails, total_checks, cycles, n;
  stc_source_model i_stc_source_model (.word_rise(WA), .word_fall(WB),
    .word_clock(word_clock), .parallel_word_in(parallel_word_in));
  stc_serializer_tx #(.SYNC_BURST_LEN(BURSTN), .LOCK_CYCLES(LOCKN)) i_stc_serializer_tx (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .word_clock(word_clock),
    .capture_edge_select(capture_edge_select), .parallel_word_in(parallel_word_in),
    .pattern_request_a(pattern_request_a), .pattern_request_b(pattern_request_b),
    .serial_out_enable(serial_out_enable), .sleep_control(sleep_control),
    .serial_p_out(serial_p_out), .serial_p_oe(serial_p_oe), .serial_n_out(serial_n_out),
    .serial_n_oe(serial_n_oe), .serial_symbol(serial_symbol), .symbol_strobe(symbol_strobe));
  task automatic summarize;
  begin
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string msg);
  begin
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] r);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic next_sym;
    do @(posedge hclk); while (symbol_strobe !== 1'b1);
  endtask
  task automatic req(input logic a, b);
  begin
    @(posedge hclk);
    pattern_request_a <= a;
    pattern_request_b <= b;
  end
  endtask
  task automatic count_sync(output int k);
  begin
    k = 0;
    repeat (30)
    begin
      next_sym;
      if (serial_symbol === stc_pkg::SYNC_SYMBOL)
        break;
    end
    while (serial_symbol === stc_pkg::SYNC_SYMBOL)
    begin
      k++;
      next_sym;
    end
  end
  endtask
  task automatic t_reset;
  begin
    ahb(1'b0, 32'h0000_0000, 32'h0, rd);
    chk_word(rd, 32'h0000_0001, "ctrl reset");
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk_word(rd, 32'h0000_0000, "unmapped read");
    chk_word(hresp, 32'h0, "response okay");
    chk_word(serial_p_oe, 32'h0, "oe in sleep");
  end
  endtask
  task automatic t_lock;
  begin
    @(posedge hclk);
    sleep_control <= 1'b1;
    serial_out_enable <= 1'b1;
    ahb(1'b0, 32'h0000_0004, 32'h0, rd);
    chk_word(rd & 32'h1, 32'h0, "locked too soon");
    n = 4;
    do
    begin
      @(posedge hclk);
      n++;
    end while (symbol_strobe !== 1'b1);
    chk_word(n >= LOCKN * 8, 32'h1, "symbol before lock");
    ahb(1'b0, 32'h0000_0004, 32'h0, rd);
    chk_word(rd & 32'h1, 32'h1, "not locked");
    chk_word({serial_p_oe, serial_n_oe}, 32'h3, "oe after lock");
  end
  endtask
  task automatic t_capture(input logic sel, input logic [9:0] w);
  begin
    @(posedge hclk);
    capture_edge_select <= sel;
    repeat (4) next_sym;
    chk_word(serial_symbol, {stc_pkg::START_BIT, w, stc_pkg::STOP_BIT}, "word");
    // symbol stands a full word period, longer than one read
    ahb(1'b0, 32'h0000_0008, 32'h0, rd);
    chk_word(rd, {20'h0, stc_pkg::START_BIT, w, stc_pkg::STOP_BIT}, "symbol reg");
  end
  endtask
  task automatic t_short;
  begin
    req(1'b1, 1'b0);
    wait_cyc(32);
    req(1'b0, 1'b0);
    repeat (12)
    begin
      next_sym;
      chk_word(serial_symbol === stc_pkg::SYNC_SYMBOL, 32'h0, "short request");
    end
  end
  endtask
  task automatic t_burst(input logic a, b);
  begin
    req(a, b);
    // the burst starts while the request is still high, so count from the start
    fork
      begin
        wait_cyc(56);
        req(1'b0, 1'b0);
      end
      count_sync(n);
    join
    chk_word(n >= BURSTN, 32'h1, "burst too short");
  end
  endtask
  task automatic t_long;
  begin
    req(1'b0, 1'b1);
    fork
      begin
        wait_cyc(320);
        req(1'b0, 1'b0);
      end
      count_sync(n);
    join
    chk_word(n >= 32, 32'h1, "held request");
  end
  endtask
  task automatic t_gate;
  begin
    @(posedge hclk);
    serial_out_enable <= 1'b0;
    wait_cyc(6);
    chk_word({serial_p_oe, serial_n_oe}, 32'h0, "oe off");
    serial_out_enable <= 1'b1;
    ahb(1'b1, 32'h0000_0000, 32'h0, rd);
    wait_cyc(4);
    chk_word(serial_p_oe, 32'h0, "gate off");
    ahb(1'b1, 32'h0000_0000, 32'h1, rd);
    wait_cyc(4);
    chk_word(serial_p_oe, 32'h1, "gate on");
  end
  endtask
  task automatic t_sleep;
  begin
    @(posedge hclk);
    sleep_control <= 1'b0;
    wait_cyc(8);
    chk_word({serial_p_oe, serial_n_oe}, 32'h0, "oe in sleep");
    ahb(1'b0, 32'h0000_0004, 32'h0, rd);
    chk_word(rd & 32'h1, 32'h0, "lock kept in sleep");
  end
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ceiling well above the roughly 1000 cycles the run needs
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      summarize;
    end
  end
  initial
  begin
    {fails, total_checks, cycles} = '0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {capture_edge_select, pattern_request_a, pattern_request_b} = 3'h4;
    {serial_out_enable, sleep_control} = 2'h0;
    wait_cyc(10);
    hresetn <= 1'b1;
    t_reset;
    t_lock;
    t_capture(1'b1, WA);
    t_capture(1'b0, WB);
    t_capture(1'b1, WA);
    t_short;
    t_burst(1'b1, 1'b0);
    t_burst(1'b0, 1'b1);
    t_long;
    t_gate;
    t_sleep;
    summarize;
  end
endmodule // tb_stc_serializer_tx
